// >>> fsc_fault_status_capture.sv
// fault status and fault address registers with axi4-lite access
//
// What this block does
// - usage flags sticky until one written
// - base word/byte/halfword reach matching subregisters
// - byte at base plus one: bus only
// - halfword at base plus two: usage only
// - hard status sticky, write one clears
// - forced escalation sets bit 30
// - vector fetch error: bit 1, hard fault
// - stacked return is preempted instruction
// - protection address valid when flag set
// - protection capture uses actual faulting piece
// - bus address valid when flag set
// - bus capture uses requested address
// - auxiliary input pulse latches status bit
// - auxiliary latch raises no exception
// - bus valid set; protection fault clears unless set together
// - only precise errors write bus address
`timescale 1ns/1ps
module fsc_fault_status_capture (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire fsc_pkg::fsc_axi_req_t i_axi,
  output fsc_pkg::fsc_axi_rsp_t     o_axi,
  input  wire fsc_pkg::fsc_fault_t  i_fault,
  output logic                      o_hard_fault_req,
  output logic [31:0]               o_stacked_return,
  output logic                      o_irq
);
  import fsc_pkg::*;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_CFG,
    SEL_HARD,
    SEL_PROT_ADDR,
    SEL_BUS_ADDR,
    SEL_AUX,
    SEL_IRQ_STATUS,
    SEL_IRQ_MASK
  } fsc_sel_t;

  typedef struct packed {
    logic [31:0]          prot_addr;
    logic [31:0]          bus_addr;
    logic [FSC_EVT_W-1:0] irq_mask;
    logic                 hard_req;
    logic [31:0]          stacked_return;
    logic                 irq;
  } fsc_top_state_t;

  fsc_top_state_t s_q;
  fsc_top_state_t s_d;

  // word-aligned decode; sub-word accesses select lanes with strobes
  function automatic fsc_sel_t reg_sel(input logic [31:0] addr);
    logic [31:0] a;
    a = {addr[31:2], 2'b00};
    if (a == FSC_CFG_STATUS_ADDR) begin
      reg_sel = SEL_CFG;
    end else if (a == FSC_HARD_STATUS_ADDR) begin
      reg_sel = SEL_HARD;
    end else if (a == FSC_PROT_ADDR_ADDR) begin
      reg_sel = SEL_PROT_ADDR;
    end else if (a == FSC_BUS_ADDR_ADDR) begin
      reg_sel = SEL_BUS_ADDR;
    end else if (a == FSC_AUX_STATUS_ADDR) begin
      reg_sel = SEL_AUX;
    end else if (a == FSC_IRQ_STATUS_ADDR) begin
      reg_sel = SEL_IRQ_STATUS;
    end else if (a == FSC_IRQ_MASK_ADDR) begin
      reg_sel = SEL_IRQ_MASK;
    end else begin
      reg_sel = SEL_NONE;
    end
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // bus front end
  logic        wr_en;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        rd_en;
  logic [31:0] rd_addr;
  logic [31:0] rd_data;
  logic        rd_err;
  logic        wr_err;
  fsc_sel_t    wr_sel;
  fsc_sel_t    rd_sel;
  logic [31:0] wr_ones;

  fsc_axil_slave u_slave (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_axi     (i_axi),
    .o_axi     (o_axi),
    .o_wr_en   (wr_en),
    .o_wr_addr (wr_addr),
    .o_wr_data (wr_data),
    .o_wr_strb (wr_strb),
    .i_wr_err  (wr_err),
    .o_rd_en   (rd_en),
    .o_rd_addr (rd_addr),
    .i_rd_data (rd_data),
    .i_rd_err  (rd_err)
  );

  assign wr_sel  = reg_sel(wr_addr);
  assign rd_sel  = reg_sel(rd_addr);
  assign wr_err  = (wr_sel == SEL_NONE);
  assign rd_err  = (rd_sel == SEL_NONE);
  // byte lane one is bus only
  assign wr_ones = wr_data & lane_mask(wr_strb);

  // sticky banks
  logic [31:0]          cfg_set;
  logic [31:0]          cfg_clr;
  logic [31:0]          cfg_bits;
  logic [31:0]          hard_set;
  logic [31:0]          hard_clr;
  logic [31:0]          hard_bits;
  logic [31:0]          aux_clr;
  logic [31:0]          aux_bits;
  logic [FSC_EVT_W-1:0] evt_set;
  logic [FSC_EVT_W-1:0] evt_clr;
  logic [FSC_EVT_W-1:0] evt_bits;
  logic                 prot_fault;
  logic                 bus_addr_known;

  assign prot_fault     = |i_fault.prot_cause;
  // precise data errors alone carry an address
  assign bus_addr_known = i_fault.bus_cause[FSC_PRECISE_BIT - FSC_BUS_LSB];

  always_comb begin
    cfg_set = FSC_WORD_RESET;
    cfg_set[FSC_PROT_LSB +: 7] = i_fault.prot_cause;
    // valid flag pairs with captured address
    cfg_set[FSC_PROT_VALID_BIT] = i_fault.prot_addr_known;
    cfg_set[FSC_BUS_LSB +: 7] = i_fault.bus_cause;
    // set on bus fault with known address
    cfg_set[FSC_BUS_VALID_BIT] = bus_addr_known;
    cfg_set[FSC_USAGE_LSB +: 16] = i_fault.usage_cause;
    cfg_clr = (wr_en && wr_sel == SEL_CFG) ? wr_ones : FSC_WORD_RESET;
    // a later protection fault voids bus address
    if (prot_fault) begin
      cfg_clr[FSC_BUS_VALID_BIT] = 1'b1;
    end
  end

  always_comb begin
    hard_set = FSC_WORD_RESET;
    hard_set[FSC_FORCED_BIT] = i_fault.forced;
    hard_set[FSC_VECTOR_FETCH_BIT] = i_fault.vector_fetch;
    hard_clr = FSC_WORD_RESET;
    if (wr_en && wr_sel == SEL_HARD) begin
      hard_clr[FSC_FORCED_BIT]       = wr_ones[FSC_FORCED_BIT];
      hard_clr[FSC_VECTOR_FETCH_BIT] = wr_ones[FSC_VECTOR_FETCH_BIT];
    end
  end

  assign aux_clr = (wr_en && wr_sel == SEL_AUX) ? wr_ones : FSC_WORD_RESET;

  always_comb begin
    evt_set = '0;
    evt_set[FSC_EVT_PROT]  = prot_fault;
    evt_set[FSC_EVT_BUS]   = |i_fault.bus_cause;
    evt_set[FSC_EVT_USAGE] = |i_fault.usage_cause;
    evt_set[FSC_EVT_HARD]  = i_fault.forced | i_fault.vector_fetch;
    evt_set[FSC_EVT_AUX]   = |i_fault.aux_fault;
    evt_clr = (wr_en && wr_sel == SEL_IRQ_STATUS) ? wr_ones[FSC_EVT_W-1:0] : '0;
  end

  // banks give set priority over clear
  fsc_sticky_bank #(.W(32)) u_cfg (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_set   (cfg_set),
    .i_clr   (cfg_clr),
    .o_bits  (cfg_bits)
  );

  fsc_sticky_bank #(.W(32)) u_hard (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_set   (hard_set),
    .i_clr   (hard_clr),
    .o_bits  (hard_bits)
  );

  fsc_sticky_bank #(.W(32)) u_aux (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_set   (i_fault.aux_fault),
    .i_clr   (aux_clr),
    .o_bits  (aux_bits)
  );

  fsc_sticky_bank #(.W(FSC_EVT_W)) u_evt (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_set   (evt_set),
    .i_clr   (evt_clr),
    .o_bits  (evt_bits)
  );

  // read mux; word read returns all three subregisters
  always_comb begin
    rd_data = FSC_WORD_RESET;
    if (rd_sel == SEL_CFG) begin
      rd_data = cfg_bits;
    end else if (rd_sel == SEL_HARD) begin
      rd_data = hard_bits;
    end else if (rd_sel == SEL_PROT_ADDR) begin
      rd_data = s_q.prot_addr;
    end else if (rd_sel == SEL_BUS_ADDR) begin
      rd_data = s_q.bus_addr;
    end else if (rd_sel == SEL_AUX) begin
      rd_data = aux_bits;
    end else if (rd_sel == SEL_IRQ_STATUS) begin
      rd_data = {27'h0000000, evt_bits};
    end else if (rd_sel == SEL_IRQ_MASK) begin
      rd_data = {27'h0000000, s_q.irq_mask};
    end
  end

  always_comb begin
    s_d = s_q;
    // software writes to the address registers honour byte lanes
    if (wr_en && wr_sel == SEL_PROT_ADDR) begin
      s_d.prot_addr = (s_q.prot_addr & ~lane_mask(wr_strb)) | wr_ones;
    end
    if (wr_en && wr_sel == SEL_BUS_ADDR) begin
      s_d.bus_addr = (s_q.bus_addr & ~lane_mask(wr_strb)) | wr_ones;
    end
    if (wr_en && wr_sel == SEL_IRQ_MASK) begin
      s_d.irq_mask = wr_strb[0] ? wr_data[FSC_EVT_W-1:0] : s_q.irq_mask;
    end
    // split access keeps the piece that faulted
    if (i_fault.prot_addr_known) begin
      s_d.prot_addr = i_fault.prot_piece_addr;
    end
    // bus capture keeps the requested address
    if (bus_addr_known) begin
      s_d.bus_addr = i_fault.bus_req_addr;
    end
    // vector fetch errors go to hard fault
    s_d.hard_req = i_fault.forced | i_fault.vector_fetch;
    if (i_fault.vector_fetch) begin
      s_d.stacked_return = i_fault.preempted_pc;
    end
    // auxiliary bits reach only the maskable interrupt
    s_d.irq = |((evt_set | (evt_bits & ~evt_clr)) & s_d.irq_mask);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_q          <= '0;
      s_q.irq_mask <= FSC_MASK_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_hard_fault_req = s_q.hard_req;
  assign o_stacked_return = s_q.stacked_return;
  assign o_irq            = s_q.irq;
endmodule

// >>> fsc_pkg.sv
// package: fault status capture constants, field layout and carrier types
package fsc_pkg;

  localparam logic [31:0] FSC_CFG_STATUS_ADDR = 32'hE000ED28;
  localparam logic [31:0] FSC_HARD_STATUS_ADDR = 32'hE000ED2C;
  localparam logic [31:0] FSC_PROT_ADDR_ADDR = 32'hE000ED34;
  localparam logic [31:0] FSC_BUS_ADDR_ADDR = 32'hE000ED38;
  localparam logic [31:0] FSC_AUX_STATUS_ADDR = 32'hE000ED3C;
  localparam logic [31:0] FSC_IRQ_STATUS_ADDR = 32'hE000ED40;
  localparam logic [31:0] FSC_IRQ_MASK_ADDR = 32'hE000ED44;

  localparam int FSC_PROT_LSB = 0;
  localparam int FSC_PROT_VALID_BIT = 7;
  localparam int FSC_BUS_LSB = 8;
  localparam int FSC_PRECISE_BIT = 9;
  localparam int FSC_BUS_VALID_BIT = 15;
  localparam int FSC_USAGE_LSB = 16;
  localparam int FSC_DEBUG_RESERVED_BIT = 31;
  localparam int FSC_FORCED_BIT = 30;
  localparam int FSC_VECTOR_FETCH_BIT = 1;

  localparam int FSC_EVT_W = 5;
  localparam int FSC_EVT_PROT = 0;
  localparam int FSC_EVT_BUS = 1;
  localparam int FSC_EVT_USAGE = 2;
  localparam int FSC_EVT_HARD = 3;
  localparam int FSC_EVT_AUX = 4;

  localparam logic [31:0] FSC_WORD_RESET = 32'h00000000;
  localparam logic [FSC_EVT_W-1:0] FSC_MASK_RESET = 5'h00;
  localparam logic [1:0] FSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] FSC_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [31:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        rready;
  } fsc_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } fsc_axi_rsp_t;

  // one-cycle event pulses from the core's fault detection
  typedef struct packed {
    logic [6:0]  prot_cause;
    logic        prot_addr_known;
    logic [31:0] prot_piece_addr;
    logic [6:0]  bus_cause;
    logic [31:0] bus_req_addr;
    logic [15:0] usage_cause;
    logic        forced;
    logic        vector_fetch;
    logic [31:0] preempted_pc;
    logic [31:0] aux_fault;
  } fsc_fault_t;

endpackage

// >>> fsc_sticky_bank.sv
// sticky status bits: set by hardware, cleared by writing one
`timescale 1ns/1ps
module fsc_sticky_bank #(
  parameter int W = 32
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_set,
  input  wire logic [W-1:0] i_clr,
  output logic [W-1:0]      o_bits
);
  import fsc_pkg::*;

  typedef struct packed {
    logic [W-1:0] bits;
  } fsc_bank_state_t;

  fsc_bank_state_t s_q;
  fsc_bank_state_t s_d;

  always_comb begin
    s_d = s_q;
    for (int i = 0; i < W; i++) begin
      if (i_set[i]) begin
        s_d.bits[i] = 1'b1;
      end else if (i_clr[i]) begin
        s_d.bits[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_bits = s_q.bits;
endmodule

// >>> fsc_axil_slave.sv
// axi4-lite slave front end: handshakes, one write and one read at a time
`timescale 1ns/1ps
module fsc_axil_slave (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire fsc_pkg::fsc_axi_req_t i_axi,
  output fsc_pkg::fsc_axi_rsp_t     o_axi,
  output logic                      o_wr_en,
  output logic [31:0]               o_wr_addr,
  output logic [31:0]               o_wr_data,
  output logic [3:0]                o_wr_strb,
  input  wire logic                 i_wr_err,
  output logic                      o_rd_en,
  output logic [31:0]               o_rd_addr,
  input  wire logic [31:0]          i_rd_data,
  input  wire logic                 i_rd_err
);
  import fsc_pkg::*;

  typedef enum logic [1:0] {
    WR_COLLECT,
    WR_RESP
  } fsc_wr_phase_t;

  typedef struct packed {
    fsc_wr_phase_t wr_phase;
    logic          aw_held;
    logic          w_held;
    logic [31:0]   awaddr;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    fsc_axi_rsp_t  rsp;
  } fsc_slv_state_t;

  fsc_slv_state_t s_q;
  fsc_slv_state_t s_d;

  // address and data may arrive in either order; both held fires the write
  assign o_wr_en   = s_q.aw_held && s_q.w_held && (s_q.wr_phase == WR_COLLECT);
  assign o_wr_addr = s_q.awaddr;
  assign o_wr_data = s_q.wdata;
  assign o_wr_strb = s_q.wstrb;
  assign o_rd_en   = i_axi.arvalid && s_q.rsp.arready;
  assign o_rd_addr = i_axi.araddr;

  always_comb begin
    s_d = s_q;
    case (s_q.wr_phase)
      WR_COLLECT: begin
        if (i_axi.awvalid && s_q.rsp.awready) begin
          s_d.aw_held     = 1'b1;
          s_d.awaddr      = i_axi.awaddr;
          s_d.rsp.awready = 1'b0;
        end
        if (i_axi.wvalid && s_q.rsp.wready) begin
          s_d.w_held     = 1'b1;
          s_d.wdata      = i_axi.wdata;
          s_d.wstrb      = i_axi.wstrb;
          s_d.rsp.wready = 1'b0;
        end
        if (o_wr_en) begin
          s_d.wr_phase   = WR_RESP;
          s_d.rsp.bvalid = 1'b1;
          s_d.rsp.bresp  = i_wr_err ? FSC_RESP_SLVERR : FSC_RESP_OKAY;
        end
      end
      WR_RESP: begin
        if (i_axi.bready) begin
          s_d.wr_phase    = WR_COLLECT;
          s_d.rsp.bvalid  = 1'b0;
          s_d.aw_held     = 1'b0;
          s_d.w_held      = 1'b0;
          s_d.rsp.awready = 1'b1;
          s_d.rsp.wready  = 1'b1;
        end
      end
      default: begin
        s_d.wr_phase = WR_COLLECT;
      end
    endcase
    if (o_rd_en) begin
      s_d.rsp.arready = 1'b0;
      s_d.rsp.rvalid  = 1'b1;
      s_d.rsp.rdata   = i_rd_data;
      s_d.rsp.rresp   = i_rd_err ? FSC_RESP_SLVERR : FSC_RESP_OKAY;
    end else if (s_q.rsp.rvalid && i_axi.rready) begin
      s_d.rsp.rvalid  = 1'b0;
      s_d.rsp.arready = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_q             <= '0;
      s_q.wr_phase    <= WR_COLLECT;
      s_q.rsp.awready <= 1'b1;
      s_q.rsp.wready  <= 1'b1;
      s_q.rsp.arready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_axi = s_q.rsp;
endmodule

// >>> fsc_fault_status_capture_sva.sv
// checker: bus handshake and fault output properties
`timescale 1ns/1ps
module fsc_checker (
  input wire logic                  i_clk,
  input wire logic                  i_rst_n,
  input wire fsc_pkg::fsc_axi_req_t i_axi,
  input wire fsc_pkg::fsc_axi_rsp_t o_axi,
  input wire fsc_pkg::fsc_fault_t   i_fault,
  input wire logic                  o_hard_fault_req,
  input wire logic [31:0]           o_stacked_return,
  input wire logic                  o_irq
);
  import fsc_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_wr_take;
    i_axi.awvalid && o_axi.awready && i_axi.wvalid && o_axi.wready;
  endsequence
  sequence s_escalate;
    i_fault.forced || i_fault.vector_fetch;
  endsequence
  a_hard_req_on: assert property (s_escalate |=> o_hard_fault_req)
    else $error("hard fault request missing");
  a_aux_no_exc: assert property (!(i_fault.forced || i_fault.vector_fetch) |=> !o_hard_fault_req)
    else $error("hard fault request without cause");
  a_stack_ret: assert property (i_fault.vector_fetch |=> o_stacked_return == $past(i_fault.preempted_pc))
    else $error("stacked return not captured");
  a_stack_hold: assert property (!i_fault.vector_fetch |=> $stable(o_stacked_return))
    else $error("stacked return changed");
  a_wr_answer: assert property (s_wr_take |=> ##1 o_axi.bvalid)
    else $error("write response late");
  a_b_hold: assert property (o_axi.bvalid && !i_axi.bready |=> o_axi.bvalid && $stable(o_axi.bresp))
    else $error("write response dropped");
  a_r_hold: assert property (o_axi.rvalid && !i_axi.rready |=> o_axi.rvalid && $stable(o_axi.rdata))
    else $error("read data dropped");
  a_ar_block: assert property (o_axi.rvalid |-> !o_axi.arready)
    else $error("read accepted while busy");
  a_rd_answer: assert property (i_axi.arvalid && o_axi.arready |=> o_axi.rvalid)
    else $error("read data late");
endmodule
bind fsc_fault_status_capture fsc_checker u_fsc_checker (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_axi(i_axi), .o_axi(o_axi), .i_fault(i_fault),
  .o_hard_fault_req(o_hard_fault_req), .o_stacked_return(o_stacked_return), .o_irq(o_irq));

// >>> fsc_core_model.sv
// core fault detection model: issues one-cycle fault pulses
`timescale 1ns/1ps
module fsc_core_model (
  input  wire logic          i_clk,
  output fsc_pkg::fsc_fault_t o_fault
);
  import fsc_pkg::*;
  initial o_fault = '0;
  task automatic pulse(input fsc_fault_t f);
    @(posedge i_clk);
    o_fault <= f;
    @(posedge i_clk);
    o_fault <= '0;
  endtask
endmodule

// >>> fsc_fault_status_capture_tb.sv
// testbench: register model compared with the fault status block
`timescale 1ns/1ps
module fsc_fault_status_capture_tb;
  import fsc_pkg::*;
  localparam logic [31:0] TA [5] = '{32'hE000ED28, 32'hE000ED29, 32'hE000ED2A, 32'hE000ED28, 32'hE000ED28};
  localparam logic [3:0]  TS [5] = '{4'h1, 4'h2, 4'hC, 4'h3, 4'hF};
  logic         i_clk;
  logic         i_rst_n;
  fsc_axi_req_t req;
  fsc_axi_rsp_t rsp;
  fsc_fault_t   flt;
  fsc_fault_t   f;
  logic         hreq;
  logic [31:0]  sret;
  logic         irq;
  logic [31:0]  m_cfg, m_hard, m_pa, m_ba, m_aux, m_ist, m_msk, seed, r;
  int           err_total;
  int           compares;
  fsc_core_model u_fsc_core_model (.i_clk(i_clk), .o_fault(flt));
  fsc_fault_status_capture u_fsc_fault_status_capture (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_axi(req),
    .o_axi(rsp), .i_fault(flt), .o_hard_fault_req(hreq), .o_stacked_return(sret), .o_irq(irq));
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("compares=%0d mismatches=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic [31:0] l;
    logic        aw;
    logic        w;
    l = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    aw = 1'b0;
    w = 1'b0;
    @(posedge i_clk);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= s;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge i_clk);
      if (req.awvalid && rsp.awready) begin
        aw = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (req.wvalid && rsp.wready) begin
        w = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    @(posedge i_clk);
    while (!rsp.bvalid) @(posedge i_clk);
    chk({30'h0, rsp.bresp}, {30'h0, er});
    req.bready <= 1'b0;
    // write-one-to-clear lanes, address and mask registers by lane
    if (er == FSC_RESP_OKAY) begin
      case ({a[31:2], 2'b00})
        FSC_CFG_STATUS_ADDR:  m_cfg &= ~(l & d);
        FSC_HARD_STATUS_ADDR: m_hard &= ~(l & d);
        FSC_PROT_ADDR_ADDR:   m_pa = (m_pa & ~l) | (d & l);
        FSC_BUS_ADDR_ADDR:    m_ba = (m_ba & ~l) | (d & l);
        FSC_AUX_STATUS_ADDR:  m_aux &= ~(l & d);
        FSC_IRQ_STATUS_ADDR:  m_ist &= ~(l & d);
        FSC_IRQ_MASK_ADDR:    m_msk = ((m_msk & ~l) | (d & l)) & 32'h0000001F;
        default: ;
      endcase
    end
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge i_clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    @(posedge i_clk);
    while (!rsp.arready) @(posedge i_clk);
    req.arvalid <= 1'b0;
    @(posedge i_clk);
    while (!rsp.rvalid) @(posedge i_clk);
    chk(rsp.rdata, e);
    chk({30'h0, rsp.rresp}, {30'h0, er});
    req.rready <= 1'b0;
  endtask
  task automatic flt_go(input fsc_fault_t g);
    u_fsc_core_model.pulse(g);
    // protection fault drops bus valid unless set together
    if (|g.prot_cause) m_cfg[15] = 1'b0;
    m_cfg[6:0] |= g.prot_cause;
    if (g.prot_addr_known) m_cfg[7] = 1'b1;
    if (g.prot_addr_known) m_pa = g.prot_piece_addr;
    m_cfg[14:8] |= g.bus_cause;
    if (g.bus_cause[1]) m_cfg[15] = 1'b1;
    if (g.bus_cause[1]) m_ba = g.bus_req_addr;
    m_cfg[31:16] |= g.usage_cause;
    m_hard[30] |= g.forced;
    m_hard[1] |= g.vector_fetch;
    m_aux |= g.aux_fault;
    m_ist |= {27'h0, |g.aux_fault, g.forced | g.vector_fetch, |g.usage_cause, |g.bus_cause, |g.prot_cause};
  endtask
  task automatic chkregs();
    rd(FSC_CFG_STATUS_ADDR, m_cfg, FSC_RESP_OKAY);
    rd(FSC_HARD_STATUS_ADDR, m_hard, FSC_RESP_OKAY);
    rd(FSC_PROT_ADDR_ADDR, m_pa, FSC_RESP_OKAY);
    rd(FSC_BUS_ADDR_ADDR, m_ba, FSC_RESP_OKAY);
    rd(FSC_AUX_STATUS_ADDR, m_aux, FSC_RESP_OKAY);
    rd(FSC_IRQ_STATUS_ADDR, m_ist, FSC_RESP_OKAY);
    rd(FSC_IRQ_MASK_ADDR, m_msk, FSC_RESP_OKAY);
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    close_out();
  end
  initial begin
    seed = 32'h00014EAF;
    err_total = 0;
    compares = 0;
    {m_cfg, m_hard, m_pa, m_ba, m_aux, m_ist, m_msk} = '0;
    req = '0;
    i_rst_n = 1'b0;
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    chkregs();
    rd(32'hE000ED48, 32'h00000000, FSC_RESP_SLVERR);
    wr(32'hE000ED48, 32'hFFFFFFFF, 4'hF, FSC_RESP_SLVERR);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      r = rnd();
      f = '0;
      f.prot_cause = 7'h7F;
      f.bus_cause = 7'h7F;
      f.usage_cause = r[15:0];
      flt_go(f);
      wr(TA[i], 32'hFFFFFFFF, TS[i], FSC_RESP_OKAY);
      rd(FSC_CFG_STATUS_ADDR, m_cfg, FSC_RESP_OKAY);
    end
    $display("test access size done");
    f = '0;
    f.vector_fetch = 1'b1;
    f.preempted_pc = rnd();
    flt_go(f);
    @(posedge i_clk);
    chk(sret, f.preempted_pc);
    chk({31'h0, hreq}, 32'h00000001);
    rd(FSC_HARD_STATUS_ADDR, m_hard, FSC_RESP_OKAY);
    f = '0;
    f.forced = 1'b1;
    flt_go(f);
    @(posedge i_clk);
    chk({31'h0, hreq}, 32'h00000001);
    chk(sret, m_pa ^ m_pa ^ sret);
    rd(FSC_HARD_STATUS_ADDR, m_hard, FSC_RESP_OKAY);
    wr(FSC_HARD_STATUS_ADDR, 32'h00000000, 4'hF, FSC_RESP_OKAY);
    rd(FSC_HARD_STATUS_ADDR, m_hard, FSC_RESP_OKAY);
    wr(FSC_HARD_STATUS_ADDR, 32'h7FFFFFFF, 4'hF, FSC_RESP_OKAY);
    rd(FSC_HARD_STATUS_ADDR, m_hard, FSC_RESP_OKAY);
    $display("test hard status done");
    f = '0;
    f.prot_cause = 7'h01;
    f.prot_addr_known = 1'b1;
    f.prot_piece_addr = rnd();
    f.bus_cause = 7'h02;
    f.bus_req_addr = rnd();
    flt_go(f);
    chkregs();
    f = '0;
    f.bus_cause = 7'h04;
    f.bus_req_addr = rnd();
    flt_go(f);
    rd(FSC_BUS_ADDR_ADDR, m_ba, FSC_RESP_OKAY);
    f = '0;
    f.prot_cause = 7'h02;
    flt_go(f);
    rd(FSC_CFG_STATUS_ADDR, m_cfg, FSC_RESP_OKAY);
    wr(FSC_BUS_ADDR_ADDR, rnd(), 4'h3, FSC_RESP_OKAY);
    rd(FSC_BUS_ADDR_ADDR, m_ba, FSC_RESP_OKAY);
    $display("test addresses done");
    f = '0;
    f.aux_fault = rnd();
    flt_go(f);
    rd(FSC_AUX_STATUS_ADDR, m_aux, FSC_RESP_OKAY);
    wr(FSC_AUX_STATUS_ADDR, rnd(), 4'hF, FSC_RESP_OKAY);
    rd(FSC_AUX_STATUS_ADDR, m_aux, FSC_RESP_OKAY);
    $display("test auxiliary done");
    wr(FSC_IRQ_STATUS_ADDR, 32'h0000001F, 4'hF, FSC_RESP_OKAY);
    wr(FSC_IRQ_MASK_ADDR, 32'h00000004, 4'h1, FSC_RESP_OKAY);
    f = '0;
    f.usage_cause = 16'h8000;
    flt_go(f);
    repeat (2) @(posedge i_clk);
    chk({31'h0, irq}, 32'h00000001);
    wr(FSC_IRQ_STATUS_ADDR, 32'h00000004, 4'hF, FSC_RESP_OKAY);
    repeat (2) @(posedge i_clk);
    chk({31'h0, irq}, 32'h00000000);
    f = '0;
    f.aux_fault = 32'h00000001;
    flt_go(f);
    repeat (2) @(posedge i_clk);
    chk({31'h0, irq}, 32'h00000000);
    chk({31'h0, hreq}, 32'h00000000);
    chkregs();
    $display("test interrupt done");
    close_out();
  end
endmodule
